// ===== hdl/eaw_top.sv
/*
 * Electrical angle timer and waveform arithmetic unit with an
 * AHB-Lite register slave.
 * Assumes the PWM generator supplies its period value and takes the
 * U, V, W compare values; position detect is a one-cycle pulse.
 */
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
module eaw_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        position_detect,
   input  wire logic [15:0] pwm_period_value,
   output logic [15:0]      cmp_u,
   output logic [15:0]      cmp_v,
   output logic [15:0]      cmp_w,
   output logic             angle_irq
);
   logic [7:0]  ctrl_a;
   logic        sync_calc_enable;
   logic        irq_source_select;
   logic [15:0] period_setting;
   logic [8:0]  angle_counter;
   logic [8:0]  angle_capture;
   logic [15:0] amplitude_value;
   logic [15:0] result [3];
   logic [15:0] work [2];
   logic        wr_pend;
   logic [7:0]  wr_addr;
   logic        prescale_tick;
   logic [11:0] step_count;
   logic [3:0]  corr_acc;
   logic        step_done;
   logic [11:0] base_eff;
   logic [4:0]  corr_sum;
   logic [11:0] step_target;
   eaw_pkg::eaw_calc_state_t calc_state;
   logic [1:0]  phase_idx;
   logic [8:0]  calc_angle;
   logic [8:0]  phase_angle;
   logic [23:0] product;
   logic [7:0]  sine_data;
   logic        calc_start;
   logic        calc_done;
   logic        angle_wr;
   logic        table_wr;
   logic        soft_start;
   logic        xfer_active;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // wrap-around add within 0..383
   function automatic logic [8:0] angle_add(input logic [8:0] a, input logic [8:0] b);
      logic [9:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s > {1'b0, eaw_pkg::ANGLE_MAX})
         angle_add = 9'(s - 10'h180);
      else
         angle_add = s[8:0];
   endfunction : angle_add

   function automatic logic [8:0] angle_sub(input logic [8:0] a, input logic [8:0] b);
      if (a >= b)
         angle_sub = a - b;
      else
         angle_sub = 9'(10'h180 + {1'b0, a} - {1'b0, b});
   endfunction : angle_sub

   eaw_prescale u_prescale (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .clk_select (ctrl_a[eaw_pkg::A_CLK_HI:eaw_pkg::A_CLK_LO]),
      .tick       (prescale_tick)
   );

   eaw_sine_ram u_ram (
      .hclk       (hclk),
      .write_en   (table_wr),
      .write_addr (angle_counter),
      .write_data (hwdata[7:0]),
      .read_addr  (phase_angle),
      .read_data  (sine_data)
   );

   // bus address phase: writes land in the data phase, reads are prepared now
   wire addr_valid = hsel & hready & (htrans == eaw_pkg::HTRANS_NONSEQ);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend <= addr_valid & hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   wire wr_ctrl_a = wr_pend & (wr_addr == eaw_pkg::OFS_CTRL_A);
   wire wr_ctrl_b = wr_pend & (wr_addr == eaw_pkg::OFS_CTRL_B);
   wire wr_period = wr_pend & (wr_addr == eaw_pkg::OFS_PERIOD);
   wire wr_amplitude = wr_pend & (wr_addr == eaw_pkg::OFS_AMPLITUDE);
   // values above 383 are not accepted into the counter
   assign angle_wr   = wr_pend & (wr_addr == eaw_pkg::OFS_ANGLE) & (hwdata[8:0] <= eaw_pkg::ANGLE_MAX);
   assign table_wr   = wr_pend & (wr_addr == eaw_pkg::OFS_TABLE);
   assign soft_start = wr_ctrl_b & hwdata[eaw_pkg::B_SOFT_START];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctrl_a <= eaw_pkg::CTRL_A_RESET;
      else if (wr_ctrl_a)
         ctrl_a <= hwdata[7:0];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync_calc_enable  <= eaw_pkg::CTRL_B_RESET[1];
         irq_source_select <= eaw_pkg::CTRL_B_RESET[0];
      end
      else if (wr_ctrl_b)
      begin
         sync_calc_enable  <= hwdata[eaw_pkg::B_SYNC_EN];
         irq_source_select <= hwdata[eaw_pkg::B_IRQ_SEL];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         period_setting <= eaw_pkg::PERIOD_RESET;
      else if (wr_period)
         period_setting <= hwdata[15:0];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         amplitude_value <= 16'h0000;
      else if (wr_amplitude)
         amplitude_value <= hwdata[15:0];
   end

   // step timing
   wire timer_en = ctrl_a[eaw_pkg::A_TIMER_EN];
   always_comb
   begin
      base_eff = period_setting[eaw_pkg::P_BASE_HI:0];
      if (base_eff < eaw_pkg::PERIOD_MIN)
         base_eff = eaw_pkg::PERIOD_MIN;
      corr_sum = {1'b0, corr_acc} + {1'b0, period_setting[eaw_pkg::P_CORR_HI:eaw_pkg::P_CORR_LO]};
      // carry out of the accumulator spreads the n long steps evenly
      step_target = base_eff + {11'h000, corr_sum[4]};
   end

   assign step_done = timer_en & prescale_tick & (step_count + 12'h001 >= step_target);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         step_count <= 12'h000;
         corr_acc   <= 4'h0;
      end
      else if (!timer_en)
      begin
         step_count <= 12'h000;
         corr_acc   <= 4'h0;
      end
      else if (step_done)
      begin
         step_count <= 12'h000;
         corr_acc   <= corr_sum[3:0];
      end
      else if (prescale_tick)
         step_count <= step_count + 12'h001;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         angle_counter <= 9'h000;
      // cleared by a disabling write only, so an angle written while stopped survives
      else if (wr_ctrl_a && !hwdata[eaw_pkg::A_TIMER_EN])
         angle_counter <= 9'h000;
      else if (angle_wr)
         angle_counter <= hwdata[8:0];
      else if (step_done)
      begin
         if (ctrl_a[eaw_pkg::A_DIR])
            angle_counter <= angle_sub(angle_counter, 9'h001);
         else
            angle_counter <= angle_add(angle_counter, 9'h001);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         angle_capture <= 9'h000;
      else if (position_detect)
         angle_capture <= angle_counter;
   end

   // calculation start; sync starts while busy are dropped so the
   // last complete set stays in use
   wire calc_en = ctrl_a[eaw_pkg::A_CALC_EN];
   wire sync_start = calc_en & sync_calc_enable & (step_done | angle_wr);
   assign calc_start = soft_start | (sync_start & (calc_state == eaw_pkg::EAW_IDLE));

   // phase angle for the table lookup
   always_comb
   begin
      case (phase_idx)
         2'h1:    phase_angle = ctrl_a[eaw_pkg::A_ORDER] ? angle_sub(calc_angle, eaw_pkg::ANGLE_THIRD)
                                                         : angle_add(calc_angle, eaw_pkg::ANGLE_THIRD);
         2'h2:    phase_angle = ctrl_a[eaw_pkg::A_ORDER] ? angle_sub(calc_angle, eaw_pkg::ANGLE_2THIRD)
                                                         : angle_add(calc_angle, eaw_pkg::ANGLE_2THIRD);
         default: phase_angle = calc_angle;
      endcase
   end

   // three-phase: centre on half period, clamp at the rails
   function automatic logic [15:0] duty_of(input logic [23:0] p, input logic [8:0] ang,
                                          input logic mod3, input logic [15:0] per);
      logic [16:0] half_p;
      logic [16:0] half_s;
      half_p = {2'b00, per[15:1]};
      half_s = {2'b00, p[23:9]};
      if (!mod3)
         duty_of = p[23:8];
      else if (ang < eaw_pkg::ANGLE_HALF)
         duty_of = ((half_p + half_s) > 17'h0FFFF) ? 16'hFFFF : 16'(half_p + half_s);
      else
         duty_of = (half_s > half_p) ? 16'h0000 : 16'(half_p - half_s);
   endfunction : duty_of

   // about ten cycles per calculation, well inside the 35-cycle budget
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         calc_state <= eaw_pkg::EAW_IDLE;
         phase_idx  <= 2'h0;
         calc_angle <= 9'h000;
         product    <= 24'h000000;
      end
      else if (calc_start)
      begin
         calc_state <= eaw_pkg::EAW_READ;
         phase_idx  <= 2'h0;
         calc_angle <= angle_wr ? hwdata[8:0] : angle_counter;
      end
      else
      begin
         case (calc_state)
            eaw_pkg::EAW_READ:  calc_state <= eaw_pkg::EAW_MUL;
            eaw_pkg::EAW_MUL:
            begin
               product    <= 24'({16'h0000, sine_data} * {8'h00, amplitude_value});
               calc_state <= eaw_pkg::EAW_STORE;
            end
            eaw_pkg::EAW_STORE:
            begin
               phase_idx  <= phase_idx + 2'h1;
               calc_state <= (phase_idx == 2'h2) ? eaw_pkg::EAW_IDLE : eaw_pkg::EAW_READ;
            end
            default:   calc_state <= eaw_pkg::EAW_IDLE;
         endcase
      end
   end

   assign calc_done = (calc_state == eaw_pkg::EAW_STORE) & (phase_idx == 2'h2) & !calc_start;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         work[0] <= 16'h0000;
         work[1] <= 16'h0000;
      end
      else if (calc_state == eaw_pkg::EAW_STORE && phase_idx != 2'h2)
         work[phase_idx[0]] <= duty_of(product, phase_angle, ctrl_a[eaw_pkg::A_MOD3], pwm_period_value);
   end

   // results replaced only as a whole set at the end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         result[0] <= 16'h0000;
         result[1] <= 16'h0000;
         result[2] <= 16'h0000;
      end
      else if (calc_done)
      begin
         result[0] <= work[0];
         result[1] <= work[1];
         result[2] <= duty_of(product, phase_angle, ctrl_a[eaw_pkg::A_MOD3], pwm_period_value);
      end
   end

   assign xfer_active = calc_en & ctrl_a[eaw_pkg::A_XFER];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cmp_u <= 16'h0000;
         cmp_v <= 16'h0000;
         cmp_w <= 16'h0000;
      end
      else if (xfer_active)
      begin
         if (calc_done)
         begin
            cmp_u <= work[0];
            cmp_v <= work[1];
            cmp_w <= duty_of(product, phase_angle, ctrl_a[eaw_pkg::A_MOD3], pwm_period_value);
         end
      end
      else if (wr_pend)
      begin
         if (wr_addr == eaw_pkg::OFS_CMP_U)
            cmp_u <= hwdata[15:0];
         if (wr_addr == eaw_pkg::OFS_CMP_V)
            cmp_v <= hwdata[15:0];
         if (wr_addr == eaw_pkg::OFS_CMP_W)
            cmp_w <= hwdata[15:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         angle_irq <= 1'b0;
      else
         angle_irq <= irq_source_select ? calc_done : step_done;
   end

   // read data registered in the address phase; unmapped reads give zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (addr_valid && !hwrite)
      begin
         case (haddr[7:0])
            eaw_pkg::OFS_CTRL_A:    hrdata <= {24'h000000, ctrl_a};
            eaw_pkg::OFS_CTRL_B:    hrdata <= {29'h00000000, calc_state != eaw_pkg::EAW_IDLE,
                                               sync_calc_enable, irq_source_select};
            eaw_pkg::OFS_PERIOD:    hrdata <= {16'h0000, period_setting};
            eaw_pkg::OFS_ANGLE:     hrdata <= {23'h000000, angle_counter};
            eaw_pkg::OFS_CAPTURE:   hrdata <= {23'h000000, angle_capture};
            eaw_pkg::OFS_AMPLITUDE: hrdata <= {16'h0000, amplitude_value};
            eaw_pkg::OFS_CMP_U:     hrdata <= {16'h0000, xfer_active ? cmp_u : result[0]};
            eaw_pkg::OFS_CMP_V:     hrdata <= {16'h0000, xfer_active ? cmp_v : result[1]};
            eaw_pkg::OFS_CMP_W:     hrdata <= {16'h0000, xfer_active ? cmp_w : result[2]};
            default:                hrdata <= 32'h00000000;
         endcase
      end
   end
endmodule : eaw_top

// ===== hdl/eaw_pkg.sv
/*
 * Shared constants for the electrical angle timer and waveform unit:
 * register offsets, field positions, reset values, widths and the
 * calculation state type.
 * Assumes a 32-bit AHB-Lite register bus with one register per word.
 */
// Summary of operation
// - angle counter runs 0..383 and wraps to zero after 383
// - a step completes when the step prescaler reaches period m
// - period values below 010H act as 010H
// - n of every 16 steps use period m+1, evenly spread
// - angle interrupt on step or on calculation end, by select bit
// - angle counter is readable and writable while running
// - capture register latches angle on position detect event
// - sync start: calculate on step and angle write, else only soft start
// - soft start begins a calculation, aborting any one in progress
// - read-only busy flag shows whether a calculation runs
// - a calculation completes within 35 machine cycles
// - two-phase result is table entry times amplitude, divided by 256
// - three-phase: half period plus or minus half product by angle half
// - results for U, V, W in sequence, V and W at 120/240 degrees
// - phase order bit selects lead or lag of V and W
// - direction bit selects counting up or down
// - two-bit clock select, changeable while the timer runs
// - clock select 0..3 gives clock divided by 8, 16, 32, 64
// - transfer and calculation enabled: results load compare registers, writes blocked
// - transfer disabled: compare reads give results, software may write
// - timer enable starts counting; disable stops and clears to zero
// - steps shorter than a calculation keep the last complete results
package eaw_pkg;
   localparam int          ANGLE_W       = 9;
   localparam logic [8:0]  ANGLE_MAX     = 9'h17F;
   localparam logic [8:0]  ANGLE_HALF    = 9'h0C0;
   localparam logic [8:0]  ANGLE_THIRD   = 9'h080;
   localparam logic [8:0]  ANGLE_2THIRD  = 9'h100;
   localparam int          TABLE_DEPTH   = 384;
   localparam int          SINE_W        = 8;
   localparam int          DUTY_W        = 16;

   localparam logic [7:0]  OFS_CTRL_A    = 8'h00;
   localparam logic [7:0]  OFS_CTRL_B    = 8'h04;
   localparam logic [7:0]  OFS_PERIOD    = 8'h08;
   localparam logic [7:0]  OFS_ANGLE     = 8'h0C;
   localparam logic [7:0]  OFS_CAPTURE   = 8'h10;
   localparam logic [7:0]  OFS_TABLE     = 8'h14;
   localparam logic [7:0]  OFS_AMPLITUDE = 8'h18;
   localparam logic [7:0]  OFS_CMP_U     = 8'h1C;
   localparam logic [7:0]  OFS_CMP_V     = 8'h20;
   localparam logic [7:0]  OFS_CMP_W     = 8'h24;

   localparam int          A_DIR         = 7;
   localparam int          A_ORDER       = 6;
   localparam int          A_CLK_HI      = 5;
   localparam int          A_CLK_LO      = 4;
   localparam int          A_MOD3        = 3;
   localparam int          A_XFER        = 2;
   localparam int          A_CALC_EN     = 1;
   localparam int          A_TIMER_EN    = 0;
   localparam int          B_SOFT_START  = 3;
   localparam int          B_BUSY        = 2;
   localparam int          B_SYNC_EN     = 1;
   localparam int          B_IRQ_SEL     = 0;
   localparam int          P_CORR_HI     = 15;
   localparam int          P_CORR_LO     = 12;
   localparam int          P_BASE_HI     = 11;

   localparam logic [7:0]  CTRL_A_RESET  = 8'h00;
   localparam logic [1:0]  CTRL_B_RESET  = 2'h0;
   localparam logic [15:0] PERIOD_RESET  = 16'h0010;
   localparam logic [11:0] PERIOD_MIN    = 12'h010;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam int          CALC_LIMIT    = 35;

   typedef enum logic [1:0] {EAW_IDLE, EAW_READ, EAW_MUL, EAW_STORE} eaw_calc_state_t;
endpackage : eaw_pkg

// ===== hdl/eaw_prescale.sv
/*
 * Angle timer clock prescaler: one-cycle enable pulse at the clock
 * divided by 8, 16, 32 or 64.
 * Assumes the select may change at any time; a change shortens or
 * lengthens only the tick in flight.
 */
`timescale 1ns/100ps
module eaw_prescale (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [1:0] clk_select,
   output logic            tick
);
   logic [5:0] div_count;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         div_count <= 6'h00;
      else
         div_count <= div_count + 6'h01;
   end

   // divide by 2^(3+sel): tick when the low 3+sel bits are all ones
   always_comb
   begin
      case (clk_select)
         2'h0:    tick = &div_count[2:0];
         2'h1:    tick = &div_count[3:0];
         2'h2:    tick = &div_count[4:0];
         default: tick = &div_count[5:0];
      endcase
   end
endmodule : eaw_prescale

// ===== hdl/eaw_sine_ram.sv
/*
 * Sine table memory, one entry per angle count, one write port and a
 * registered read port.
 * Assumes addresses are already limited to the table range.
 */
`timescale 1ns/100ps
module eaw_sine_ram #(
   parameter int DEPTH  = eaw_pkg::TABLE_DEPTH,
   parameter int WIDTH  = eaw_pkg::SINE_W,
   parameter int ADDR_W = eaw_pkg::ANGLE_W
) (
   input  wire logic              hclk,
   input  wire logic              write_en,
   input  wire logic [ADDR_W-1:0] write_addr,
   input  wire logic [WIDTH-1:0]  write_data,
   input  wire logic [ADDR_W-1:0] read_addr,
   output logic      [WIDTH-1:0]  read_data
);
   logic [WIDTH-1:0] table_mem [DEPTH];

   // contents undefined until software fills the table
   always_ff @(posedge hclk)
   begin
      if (write_en)
         table_mem[write_addr] <= write_data;
      read_data <= table_mem[read_addr];
   end
endmodule : eaw_sine_ram

// ===== bench/eaw_props.sv
/* Checker for eaw_top: bus answer, read-back limits and interrupt width.
   Assumes one clock hclk and the active-low reset hresetn. */
`timescale 1ns/100ps
module eaw_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        angle_irq
);
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence any_rd;
      hsel && hready && htrans == 2'h2 && !hwrite;
   endsequence
   sequence rd(ofs);
      hsel && hready && htrans == 2'h2 && !hwrite && haddr[7:0] == ofs;
   endsequence
   a_ready_const: assert property (hreadyout)
      else $error("wait state inserted");
   a_resp_okay: assert property (!hresp)
      else $error("error response");
   a_irq_single: assert property (angle_irq |=> !angle_irq)
      else $error("irq wider than one cycle");
   a_angle_range: assert property (rd(8'h0C) |=> hrdata <= 32'h17F)
      else $error("angle read above range");
   a_ctrlb_bits: assert property (rd(8'h04) |=> hrdata[31:3] == 29'h0)
      else $error("start bit or spare bits read back");
   a_table_unread: assert property (rd(8'h14) |=> hrdata == 32'h0)
      else $error("table data readable");
   a_unmapped_zero: assert property (rd(8'h28) |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (any_rd |=> hrdata[31:16] == 16'h0)
      else $error("upper read bits set");
   a_rdata_hold: assert property (!(hsel && hready && htrans == 2'h2 && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");
endmodule : eaw_props

bind eaw_top eaw_props eaw_props_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .angle_irq(angle_irq));

// ===== bench/eaw_pwm_model.sv
/* Stand-in for the PWM generator: a steady period level and a carrier
   that turns the U compare value into a duty output.
   Assumes the unit reads the period as a level, never as a pulse. */
`timescale 1ns/100ps
module eaw_pwm_model #(
   parameter logic [15:0] PERIOD = 16'h1000
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [15:0] cmp_u,
   output logic      [15:0] pwm_period_value,
   output logic             u_high
);
   logic [15:0] carrier;
   assign pwm_period_value = PERIOD;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         carrier <= 16'h0;
      else
         carrier <= (carrier == PERIOD - 16'h1) ? 16'h0 : carrier + 16'h1;
   assign u_high = carrier < cmp_u;
endmodule : eaw_pwm_model

// ===== bench/tb.sv
/* Self-checking bench for eaw_top: AHB-Lite master tasks and one task
   per scenario. Assumes the PWM model supplies a fixed period. */
`timescale 1ns/100ps
module tb;
   logic        hclk, hresetn, hreadyout, hresp, angle_irq;
   logic        hsel = 1'b0, hwrite = 1'b0, position_detect = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [15:0] per, cmp_u, cmp_v, cmp_w;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
   wire         hready;
   int          err_count, check_count, n, s;
   assign hready = hreadyout;
   eaw_top eaw_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .position_detect(position_detect), .pwm_period_value(per),
      .cmp_u(cmp_u), .cmp_v(cmp_v), .cmp_w(cmp_w), .angle_irq(angle_irq));
   eaw_pwm_model eaw_pwm_model_inst (.hclk(hclk), .hresetn(hresetn), .cmp_u(cmp_u),
      .pwm_period_value(per), .u_high());
   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   task summarize;
      if (err_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   task fail;
      err_count++;
      summarize;
   endtask : fail
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task rdy;
      int k;
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (hready !== 1'b1 && k < 64);
      if (hready !== 1'b1)
         fail;
   endtask : rdy
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy;
      rv = hrdata;
   endtask : bus
   // n ends as the cycle count up to the pulse, or lim if none came
   task irq(input int lim, input logic must);
      n = 0;
      do
      begin
         @(negedge hclk);
         n++;
      end
      while (angle_irq !== 1'b1 && n < lim);
      if (must && angle_irq !== 1'b1)
         fail;
      @(posedge hclk);
   endtask : irq
   // table holds angle/2, amplitude is fixed at 200H
   function logic [15:0] res(input int a, input int k, input logic o, input logic m3);
      int p;
      int v;
      p = o ? (a + 384 - 128 * k) % 384 : (a + 128 * k) % 384;
      v = p[8:1] * 512;
      if (!m3)
         return 16'(v >> 8);
      return 16'(p < 192 ? per / 2 + (v >> 9) : per / 2 - (v >> 9));
   endfunction : res
   task t_reset;
      bus(1'b0, 8'h00, 32'h0);
      chk(rv, 32'h0);
      bus(1'b0, 8'h08, 32'h0);
      chk(rv, 32'h10);
      bus(1'b0, 8'h28, 32'h0);
      chk(rv, 32'h0);
      bus(1'b0, 8'h14, 32'h0);
      chk(rv, 32'h0);
      bus(1'b1, 8'h0C, 32'h55);
      position_detect <= 1'b1;
      @(posedge hclk);
      position_detect <= 1'b0;
      bus(1'b0, 8'h10, 32'h0);
      chk(rv, 32'h55);
   endtask : t_reset
   task t_fill;
      for (int i = 0; i < 384; i++)
      begin
         bus(1'b1, 8'h0C, 32'(i));
         bus(1'b1, 8'h14, {24'h0, i[8:1]});
      end
   endtask : t_fill
   task t_calc;
      int a;
      bus(1'b1, 8'h04, 32'h3);
      bus(1'b1, 8'h18, 32'h200);
      for (int j = 0; j < 4; j++)
      begin
         a = 20 + 70 * j;
         bus(1'b1, 8'h00, {25'h0, j[0], 2'h0, j[1], 3'h2});
         bus(1'b1, 8'h0C, 32'(a));
         irq(36, 1'b1);
         chk(32'(n <= 35), 32'h1);
         for (int k = 0; k < 3; k++)
         begin
            bus(1'b0, 8'h1C + 8'(4 * k), 32'h0);
            chk(rv, res(a, k, j[0], j[1]));
         end
      end
   endtask : t_calc
   task t_xfer;
      bus(1'b1, 8'h00, 32'h6);
      bus(1'b1, 8'h0C, 32'h28);
      irq(36, 1'b1);
      bus(1'b1, 8'h1C, 32'h1234);
      bus(1'b0, 8'h1C, 32'h0);
      chk(cmp_u, res(40, 0, 1'b0, 1'b0));
      chk(cmp_v, res(40, 1, 1'b0, 1'b0));
      chk(cmp_w, res(40, 2, 1'b0, 1'b0));
      bus(1'b1, 8'h00, 32'h2);
      bus(1'b1, 8'h1C, 32'h1234);
      bus(1'b0, 8'h1C, 32'h0);
      chk(cmp_u, 32'h1234);
      chk(rv, res(40, 0, 1'b0, 1'b0));
      bus(1'b1, 8'h0C, 32'h50);
      bus(1'b1, 8'h0C, 32'h64);
      irq(36, 1'b1);
      bus(1'b0, 8'h1C, 32'h0);
      chk(rv, res(80, 0, 1'b0, 1'b0));
   endtask : t_xfer
   task t_soft;
      bus(1'b1, 8'h04, 32'h1);
      bus(1'b1, 8'h0C, 32'h3C);
      irq(40, 1'b0);
      chk(n, 40);
      bus(1'b1, 8'h04, 32'h9);
      @(posedge hclk);
      bus(1'b0, 8'h04, 32'h0);
      chk(rv, 32'h5);
      irq(36, 1'b1);
      bus(1'b0, 8'h04, 32'h0);
      chk(rv, 32'h1);
      bus(1'b1, 8'h04, 32'h9);
      repeat (5) @(posedge hclk);
      bus(1'b1, 8'h04, 32'h9);
      irq(36, 1'b1);
      chk(32'(n >= 8), 32'h1);
   endtask : t_soft
   task t_timer;
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h04, 32'h0);
      bus(1'b1, 8'h08, 32'h5);
      for (int c = 0; c < 4; c++)
      begin
         bus(1'b1, 8'h00, {26'h0, 2'(c), 4'h1});
         irq(9000, 1'b1);
         irq(9000, 1'b1);
         chk(n, 128 << c);
      end
      bus(1'b1, 8'h00, 32'h1);
      bus(1'b1, 8'h08, 32'h8010);
      irq(9000, 1'b1);
      s = 0;
      repeat (16)
      begin
         irq(9000, 1'b1);
         s += n;
      end
      chk(s, 32'h840);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b0, 8'h0C, 32'h0);
      chk(rv, 32'h0);
      bus(1'b1, 8'h0C, 32'h17F);
      bus(1'b1, 8'h00, 32'h1);
      irq(9000, 1'b1);
      bus(1'b0, 8'h0C, 32'h0);
      chk(rv, 32'h0);
      bus(1'b1, 8'h0C, 32'h100);
      bus(1'b0, 8'h0C, 32'h0);
      chk(rv, 32'h100);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h00, 32'h81);
      irq(9000, 1'b1);
      bus(1'b0, 8'h0C, 32'h0);
      chk(rv, 32'h17F);
   endtask : t_timer
   initial
   begin
      err_count = 0;
      check_count = 0;
      hresetn = 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_fill;
      t_calc;
      t_xfer;
      t_soft;
      t_timer;
      summarize;
   end
endmodule : tb
